// >>> rtl/mie_pkg.sv
// Purpose: Constants for the miscellaneous instruction executor.
// Assumes: APB slave with 32-bit data, one register per aligned word.
// Notes: Opcodes are 10-bit program words.
// How it works
// RULE_01 - RC clock select opcode selects the RC clock and stops the on-chip oscillator.
// RULE_02 - Decrement-index opcode subtracts one from the 4-bit index and stores it.
// RULE_03 - After decrement, index equal to 15 skips the next instruction.
// RULE_04 - Interrupt-mask opcode clears the enable flag; interrupts go off one cycle later.
// RULE_05 - Interrupt-unmask opcode sets the enable flag; interrupts come on one cycle later.
// RULE_06 - Watchdog-halt-arm opcode lets a later power-down stop the watchdog.
// RULE_07 - Power-down opcodes act only right after the power-down-arm opcode.
// RULE_08 - Every opcode is one word, one machine cycle, and leaves carry alone.
package mie_pkg;

  localparam int OP_W = 10;
  localparam int ADDR_W = 12;
  localparam int IDX_W = 4;

  // Documented opcodes.
  localparam logic [OP_W-1:0] OP_RC_CLOCK_SELECT = 10'h29b;
  localparam logic [OP_W-1:0] OP_DECREMENT_INDEX = 10'h017;
  localparam logic [OP_W-1:0] OP_INTERRUPT_MASK = 10'h004;
  localparam logic [OP_W-1:0] OP_INTERRUPT_UNMASK = 10'h005;
  localparam logic [OP_W-1:0] OP_POWERDOWN_ARM = 10'h05b;
  localparam logic [IDX_W-1:0] IDX_SKIP_VALUE = 4'hf;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] OFF_OPCODE = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_INDEX = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h008;

  // Index register fields.
  localparam int IDX_LSB = 0;
  localparam int IDX_CARRY_B = 8;

  // Status register bits.
  localparam int ST_INTERRUPT_ENABLE_FLAG_FLAG_B = 0;
  localparam int ST_INT_EN_B = 1;
  localparam int ST_RC_SEL_B = 2;
  localparam int ST_OSC_STOP_B = 3;
  localparam int ST_WDT_ARM_B = 4;
  localparam int ST_PD_ARM_B = 5;
  localparam int ST_SKIP_B = 6;
  localparam int ST_BAD_OP_B = 7;
  localparam int ST_PD_REFUSED_B = 8;

  // Reset values.
  localparam logic [IDX_W-1:0] RST_INDEX = 4'h0;
  localparam logic RST_CARRY = 1'b0;
  localparam logic RST_INTERRUPT_ENABLE_FLAG = 1'b0;
  localparam logic RST_RC_SEL = 1'b0;

  typedef struct packed {
    logic ready;
    logic [31:0] rdata;
    logic slverr;
    logic [OP_W-1:0] last_op;
    logic [IDX_W-1:0] idx;
    logic carry;
    logic interrupt_enable_flag_flag;
    logic int_en;
    logic rc_sel;
    logic wdt_arm;
    logic pd_arm;
    logic skip;
    logic skip_pulse;
    logic pd;
    logic pd_alt;
    logic wdt_stop;
    logic bad_op;
    logic pd_refused;
  } mie_state_t;

endpackage : mie_pkg

// >>> rtl/mie_exec.sv
// Purpose: Executes the clock, index, interrupt, watchdog and power-down opcodes.
// Assumes: One APB write to the opcode register is one machine cycle.
// Notes: Power-down and watchdog stop leave as one-cycle requests to the core.
`timescale 1ns/1ns
`default_nettype none

module mie_exec
  import mie_pkg::*;
#(
  parameter logic [OP_W-1:0] OP_WATCHDOG_HALT_ARM = 10'h29c,
  parameter logic [OP_W-1:0] OP_POWERDOWN = 10'h2a0,
  parameter logic [OP_W-1:0] OP_POWERDOWN_ALT = 10'h2a1
) (
  input wire logic CLK_I,
  input wire logic RST_B_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [ADDR_W-1:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic PREADY_O,
  output logic [31:0] PRDATA_O,
  output logic PSLVERR_O,
  output logic RC_CLK_SEL_O,
  output logic OSC_STOP_O,
  output logic INT_ENABLE_O,
  output logic [IDX_W-1:0] INDEX_O,
  output logic CARRY_O,
  output logic SKIP_O,
  output logic PWR_DOWN_O,
  output logic PWR_DOWN_ALT_O,
  output logic WDT_STOP_O
);

  mie_state_t q;
  mie_state_t next_q;
  logic access;
  logic done;
  logic hit_op;
  logic hit_idx;
  logic hit_st;
  logic [OP_W-1:0] op;
  logic [IDX_W-1:0] dec_idx;

  // Bus phase decode; the answer comes one cycle into the access phase.
  assign access = PSEL_I & PENABLE_I;
  assign done = access & q.ready;
  assign hit_op = (PADDR_I == OFF_OPCODE);
  assign hit_idx = (PADDR_I == OFF_INDEX);
  assign hit_st = (PADDR_I == OFF_STATUS);
  assign op = PWDATA_I[OP_W-1:0];
  assign dec_idx = q.idx - 4'h1; // RULE_02

  // Next-state logic for bus slave and instruction execution together.
  always_comb begin
    next_q = q;
    next_q.ready = access & ~q.ready;
    next_q.skip_pulse = 1'b0;
    next_q.pd = 1'b0;
    next_q.pd_alt = 1'b0;
    next_q.wdt_stop = 1'b0;
    // Read data and error are prepared in the first access cycle.
    if (access & ~q.ready) begin
      next_q.rdata = 32'h0;
      next_q.slverr = ~(hit_op | hit_idx | hit_st);
      if (!PWRITE_I) begin
        if (hit_op) begin
          next_q.rdata[OP_W-1:0] = q.last_op;
        end
        if (hit_idx) begin
          next_q.rdata[IDX_LSB +: IDX_W] = q.idx;
          next_q.rdata[IDX_CARRY_B] = q.carry;
        end
        if (hit_st) begin
          next_q.rdata[ST_INTERRUPT_ENABLE_FLAG_FLAG_B] = q.interrupt_enable_flag_flag;
          next_q.rdata[ST_INT_EN_B] = q.int_en;
          next_q.rdata[ST_RC_SEL_B] = q.rc_sel;
          next_q.rdata[ST_OSC_STOP_B] = q.rc_sel;
          next_q.rdata[ST_WDT_ARM_B] = q.wdt_arm;
          next_q.rdata[ST_PD_ARM_B] = q.pd_arm;
          next_q.rdata[ST_SKIP_B] = q.skip;
          next_q.rdata[ST_BAD_OP_B] = q.bad_op;
          next_q.rdata[ST_PD_REFUSED_B] = q.pd_refused;
        end
      end
    end
    // Software may load index and carry directly; instructions never touch carry.
    if (done & PWRITE_I & hit_idx) begin
      next_q.idx = PWDATA_I[IDX_LSB +: IDX_W];
      next_q.carry = PWDATA_I[IDX_CARRY_B];
    end
    // One opcode write is one whole machine cycle.
    if (done & PWRITE_I & hit_op) begin
      next_q.last_op = op;
      // The flag reaches the interrupt logic one machine cycle late.
      next_q.int_en = q.interrupt_enable_flag_flag; // RULE_04 RULE_05
      // Arming lasts exactly one instruction, so only the next one can use it.
      next_q.pd_arm = 1'b0; // RULE_07
      next_q.bad_op = 1'b0;
      next_q.pd_refused = 1'b0;
      if (q.skip) begin
        // A skipped word still costs its machine cycle but does nothing.
        next_q.skip = 1'b0; // RULE_03
      end else begin
        next_q.skip = 1'b0;
        case (op)
          OP_RC_CLOCK_SELECT: begin
            next_q.rc_sel = 1'b1; // RULE_01
          end
          OP_DECREMENT_INDEX: begin
            next_q.idx = dec_idx; // RULE_02
            if (dec_idx == IDX_SKIP_VALUE) begin
              next_q.skip = 1'b1; // RULE_03
              next_q.skip_pulse = 1'b1; // RULE_03
            end
          end
          OP_INTERRUPT_MASK: begin
            next_q.interrupt_enable_flag_flag = 1'b0; // RULE_04
          end
          OP_INTERRUPT_UNMASK: begin
            next_q.interrupt_enable_flag_flag = 1'b1; // RULE_05
          end
          OP_POWERDOWN_ARM: begin
            next_q.pd_arm = 1'b1; // RULE_07
          end
          OP_WATCHDOG_HALT_ARM: begin
            next_q.wdt_arm = 1'b1; // RULE_06
          end
          OP_POWERDOWN, OP_POWERDOWN_ALT: begin
            // Without the arming word just before, power-down is refused.
            if (q.pd_arm) begin
              next_q.pd = (op == OP_POWERDOWN); // RULE_07
              next_q.pd_alt = (op == OP_POWERDOWN_ALT); // RULE_07
              next_q.wdt_stop = q.wdt_arm; // RULE_06
            end else begin
              next_q.pd_refused = 1'b1; // RULE_07
            end
          end
          default: begin
            next_q.bad_op = 1'b1;
          end
        endcase
      end
    end
  end

  // State register with synchronous active-low reset.
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      q <= '0;
      q.idx <= RST_INDEX;
      q.carry <= RST_CARRY;
      q.interrupt_enable_flag_flag <= RST_INTERRUPT_ENABLE_FLAG;
      q.int_en <= RST_INTERRUPT_ENABLE_FLAG;
      q.rc_sel <= RST_RC_SEL;
    end else begin
      q <= next_q;
    end
  end

  // Outputs come straight from state flip-flops.
  assign PREADY_O = q.ready;
  assign PRDATA_O = q.rdata;
  assign PSLVERR_O = q.slverr;
  assign RC_CLK_SEL_O = q.rc_sel; // RULE_01
  assign OSC_STOP_O = q.rc_sel; // RULE_01
  assign INT_ENABLE_O = q.int_en;
  assign INDEX_O = q.idx;
  assign CARRY_O = q.carry; // RULE_08
  assign SKIP_O = q.skip_pulse;
  assign PWR_DOWN_O = q.pd;
  assign PWR_DOWN_ALT_O = q.pd_alt;
  assign WDT_STOP_O = q.wdt_stop;

endmodule : mie_exec

`default_nettype wire

// >>> bench/mie_exec_chk.sv
// Purpose: Port checks for the instruction executor.
// Assumes: One clock; side outputs move at the edge that completes an opcode write.
// Notes: Only relations visible at the ports are checked here.
`timescale 1ns/1ns
`default_nettype none
module mie_exec_chk
  import mie_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_B_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [ADDR_W-1:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic PREADY_O,
  input wire logic RC_CLK_SEL_O,
  input wire logic OSC_STOP_O,
  input wire logic INT_ENABLE_O,
  input wire logic [IDX_W-1:0] INDEX_O,
  input wire logic CARRY_O,
  input wire logic SKIP_O,
  input wire logic PWR_DOWN_O,
  input wire logic PWR_DOWN_ALT_O,
  input wire logic WDT_STOP_O
);
  // A completed write, and a completed opcode write, which is one machine cycle.
  logic wr;
  logic op;
  logic [9:0] c;
  logic last_arm;
  logic rst_ok;
  assign wr = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I;
  assign op = wr && PADDR_I == OFF_OPCODE;
  assign c = PWDATA_I[9:0];
  // Remembers whether the latest opcode was the arming one; a skipped opcode only makes this looser.
  // Checks start one clock after reset is released, so $past never looks back before reset took hold.
  always_ff @(posedge CLK_I) begin
    rst_ok <= RST_B_I;
    if (!RST_B_I) begin
      last_arm <= 1'b0;
    end else if (op) begin
      last_arm <= c == OP_POWERDOWN_ARM;
    end
  end
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I || !rst_ok);
  rc_select_a: assert property ($rose(RC_CLK_SEL_O) |-> $past(op && c == OP_RC_CLOCK_SELECT))
    else $error("rc select without opcode");
  rc_hold_a: assert property (RC_CLK_SEL_O |=> RC_CLK_SEL_O && OSC_STOP_O)
    else $error("rc select or osc stop lost");
  idx_dec_a: assert property ($past(op) && INDEX_O != $past(INDEX_O) |-> INDEX_O == $past(INDEX_O) - 4'h1)
    else $error("index not decremented by one");
  skip_idx_a: assert property (SKIP_O |-> INDEX_O == IDX_SKIP_VALUE && $past(op && c == OP_DECREMENT_INDEX))
    else $error("skip without wrap");
  carry_hold_a: assert property ($changed(CARRY_O) |-> $past(wr && PADDR_I == OFF_INDEX))
    else $error("carry moved by opcode");
  int_delay_a: assert property ($changed(INT_ENABLE_O) |-> $past(op))
    else $error("enable moved outside machine cycle");
  pd_arm_a: assert property (PWR_DOWN_O || PWR_DOWN_ALT_O |-> $past(last_arm))
    else $error("power-down not armed");
  wdt_stop_a: assert property (WDT_STOP_O |-> PWR_DOWN_O || PWR_DOWN_ALT_O)
    else $error("watchdog stop without power-down");
endmodule : mie_exec_chk
bind mie_exec mie_exec_chk mie_exec_chk_i (
  .CLK_I(CLK_I),
  .RST_B_I(RST_B_I),
  .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I),
  .PADDR_I(PADDR_I),
  .PWDATA_I(PWDATA_I),
  .PREADY_O(PREADY_O),
  .RC_CLK_SEL_O(RC_CLK_SEL_O),
  .OSC_STOP_O(OSC_STOP_O),
  .INT_ENABLE_O(INT_ENABLE_O),
  .INDEX_O(INDEX_O),
  .CARRY_O(CARRY_O),
  .SKIP_O(SKIP_O),
  .PWR_DOWN_O(PWR_DOWN_O),
  .PWR_DOWN_ALT_O(PWR_DOWN_ALT_O),
  .WDT_STOP_O(WDT_STOP_O)
);
`default_nettype wire

// >>> bench/mie_exec_tb.sv
// Purpose: Directed bench for the instruction executor.
// Assumes: Opcode parameters at their defaults: halt arm 0x29c, power-down 0x2a0 and 0x2a1.
// Notes: Side outputs are read one step after the completing edge.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_mismatch++; $display("[ERR] %0t got %h", $time, a); end end
module mie_exec_tb
  import mie_pkg::*;
;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [ADDR_W-1:0] pa = '0;
  logic [31:0] pwd = '0;
  logic rdy, err, rc, osc, ien, cy, skp, pd, pd2, wst, e;
  logic [31:0] prd, rd;
  logic [IDX_W-1:0] idx;
  int n_mismatch = 0;
  int samples_checked = 0;
  mie_exec mie_exec_i (.CLK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(pa), .PWDATA_I(pwd), .PREADY_O(rdy), .PRDATA_O(prd), .PSLVERR_O(err), .RC_CLK_SEL_O(rc),
    .OSC_STOP_O(osc), .INT_ENABLE_O(ien), .INDEX_O(idx), .CARRY_O(cy), .SKIP_O(skp), .PWR_DOWN_O(pd),
    .PWR_DOWN_ALT_O(pd2), .WDT_STOP_O(wst));
  // Free-running core clock, 4 ns period.
  initial forever #2 clk = ~clk;
  task automatic end_of_test();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  // One APB transfer; the request holds until pready is seen or 20 clocks pass, which bounds the wait.
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 20);
    if (rdy !== 1'b1) begin
      n_mismatch++;
      end_of_test();
    end
    rd = prd;
    e = err;
    psel <= 1'b0;
    pen <= 1'b0;
    #1;
  endtask : xfer
  task automatic op(input logic [9:0] c);
    xfer(1'b1, OFF_OPCODE, {22'h0, c});
  endtask : op
  // Directed sequence; each check follows the machine cycle that should cause it.
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    xfer(1'b0, OFF_STATUS, '0);
    `CHK(rd, 32'h0)
    op(OP_DECREMENT_INDEX);
    `CHK({skp, idx}, 5'h1f)
    op(OP_RC_CLOCK_SELECT);
    `CHK({skp, rc}, 2'b00)
    op(OP_DECREMENT_INDEX);
    `CHK({skp, idx}, 5'h0e)
    op(OP_RC_CLOCK_SELECT);
    `CHK({rc, osc}, 2'b11)
    xfer(1'b1, OFF_INDEX, 32'h105);
    op(OP_DECREMENT_INDEX);
    xfer(1'b0, OFF_INDEX, '0);
    `CHK({cy, rd}, 33'h1_0000_0104)
    op(OP_INTERRUPT_UNMASK);
    xfer(1'b0, OFF_STATUS, '0);
    `CHK({rd[ST_INTERRUPT_ENABLE_FLAG_FLAG_B], ien}, 2'b10)
    op(OP_INTERRUPT_MASK);
    xfer(1'b0, OFF_STATUS, '0);
    `CHK({rd[ST_INTERRUPT_ENABLE_FLAG_FLAG_B], ien}, 2'b01)
    op(OP_DECREMENT_INDEX);
    `CHK(ien, 1'b0)
    op(10'h2a0);
    xfer(1'b0, OFF_STATUS, '0);
    `CHK({pd, rd[ST_PD_REFUSED_B]}, 2'b01)
    op(OP_POWERDOWN_ARM);
    op(10'h2a0);
    `CHK({pd, wst}, 2'b10)
    op(10'h29c);
    op(OP_POWERDOWN_ARM);
    op(10'h2a1);
    `CHK({pd2, wst}, 2'b11)
    op(OP_POWERDOWN_ARM);
    op(OP_DECREMENT_INDEX);
    op(10'h2a1);
    `CHK(pd2, 1'b0)
    // An unknown word flags itself; clock select and watchdog arming stay sticky.
    op(10'h3ff);
    xfer(1'b0, OFF_STATUS, '0);
    `CHK(rd[8:0], 9'h09c)
    xfer(1'b0, 12'h00c, '0);
    `CHK({e, rd}, 33'h1_0000_0000)
    end_of_test();
  end
endmodule : mie_exec_tb
`default_nettype wire
